// *** pkg/gpio_pkg.sv ***
// ----------------------------------------------------------------
// Shared constants and carriers of the general-purpose pin port
// ----------------------------------------------------------------
package gpio_pkg;

  // Pin counts
  localparam int PIN_COUNT = 16;   // All general-purpose pins
  localparam int IRQ_PINS  = 13;   // Pins 0..12 may interrupt
  localparam int CLK_PIN_A = 14;   // First clock-capable pin
  localparam int CLK_PIN_B = 15;   // Second clock-capable pin

  // Core clock and output clock limit
  localparam int  CORE_CLK_KHZ  = 20000;  // Core clock, 50 ns period
  localparam int  MAX_CLK_KHZ   = 33330;  // Clock output ceiling
  // Shortest legal output period in core cycles, at least two
  localparam int  MIN_PERIOD_CYC =
    ((CORE_CLK_KHZ + MAX_CLK_KHZ - 1) / MAX_CLK_KHZ) < 2 ? 2 :
    ((CORE_CLK_KHZ + MAX_CLK_KHZ - 1) / MAX_CLK_KHZ);
  localparam logic [7:0] MIN_DIV = 8'(MIN_PERIOD_CYC - 1);

  // Register byte offsets
  localparam logic [7:0] OFS_OUT     = 8'h00;  // Output data
  localparam logic [7:0] OFS_DIR     = 8'h04;  // 1 = output
  localparam logic [7:0] OFS_IN      = 8'h08;  // Pin levels
  localparam logic [7:0] OFS_INT_EN  = 8'h0C;  // Interrupt mask
  localparam logic [7:0] OFS_INT_ST  = 8'h10;  // Sticky events
  localparam logic [7:0] OFS_CLK_CFG = 8'h14;  // Clock output setup

  // Clock configuration field positions
  localparam int CLK_SEL_A_BIT = 0;   // Pin 14 drives clock
  localparam int CLK_SEL_B_BIT = 1;   // Pin 15 drives clock
  localparam int CLK_DIV_LSB   = 8;   // Period minus one
  localparam int CLK_HIGH_LSB  = 16;  // High time in cycles

  // Reset values
  localparam logic [15:0] RST_OUT    = 16'h0000;
  localparam logic [15:0] RST_DIR    = 16'h8000;  // Only pin 15 out
  localparam logic [12:0] RST_INT_EN = 13'h0000;
  localparam logic        RST_SEL_A  = 1'b0;      // Pin 14 input
  localparam logic        RST_SEL_B  = 1'b1;      // Pin 15 clock
  localparam logic [7:0]  RST_DIV    = 8'h01;     // 10 MHz
  localparam logic [7:0]  RST_HIGH   = 8'h01;     // 50 % duty

  // Clock output configuration
  typedef struct packed {
    logic [7:0] high;    // Cycles high per period
    logic [7:0] div;     // Period minus one, in core cycles
    logic       selB;    // Pin 15 drives the clock
    logic       selA;    // Pin 14 drives the clock
  } clk_cfg_t;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// *** src/gpio_clk_gen.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Programmable clock generator for the clock-capable pins
// ----------------------------------------------------------------
module gpio_clk_gen
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              run,
  input  wire gpio_pkg::clk_cfg_t cfg,
  output logic                   generated_clock_out
);
  import gpio_pkg::*;

  logic [7:0] cnt;       // Position inside one period
  logic [7:0] next_cnt;  // Following position
  wire  [7:0] lastCnt;   // Period end, clamped to the fastest rate

  // Never faster than the output ceiling allows
  assign lastCnt  = (cfg.div < MIN_DIV) ? MIN_DIV : cfg.div;
  // Wrap at the end of each period
  assign next_cnt = (cnt >= lastCnt) ? 8'h00 : cnt + 8'h01;

  // ----------------------------------------------------------------
  // Period counter and duty compare
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b || !run)
    begin
      cnt    <= 8'h00;
      generated_clock_out <= 1'b0;
    end
    else
    begin
      cnt    <= next_cnt;
      generated_clock_out <= (next_cnt < cfg.high);   // High for 'high' cycles
    end
  end

endmodule

// *** src/gpio_port.sv ***
`timescale 1ns/10ps
// How it works
// - Each pin individually input or output
// - Pins 0-12 inputs may raise interrupts
// - Pins 0-13 inputs, drivers off after reset
// - Pin 14 input after reset
// - Pins 14,15 drive programmable duty clock
// - Pin 15 output driving clock after reset
// - Pin 15 clock available for expansion bus
// - Pins float until resets release and lock
// - Locked output reports synthesizer lock
module gpio_port
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             power_up_reset_in_n,
  input  wire logic             synthLockIn,
  input  wire gpio_pkg::wb_req_t wbReq,
  output logic                  wbAck,
  output logic [31:0]           wbRdData,
  input  wire logic [15:0]      pinIn,
  output logic [15:0]           pinOut,
  output logic [15:0]           pinOe,
  output logic                  synthLocked,
  output logic                  irq
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] outData;      // Software output levels
  logic [15:0] dir;          // 1 drives the pin
  logic [12:0] intEn;        // Interrupt mask
  logic [12:0] intStat;      // Sticky edge events
  clk_cfg_t    clkCfg;       // Clock output setup
  logic [15:0] inMeta;       // First synchroniser stage
  logic [15:0] inSync;       // Second synchroniser stage
  logic [15:0] inLast;       // Previous synchronised level
  logic        porMeta;      // Power-up reset, first stage
  logic        porSync;      // Power-up reset, second stage
  logic        lockMeta;     // Lock, first stage
  logic        lockSync;     // Lock, second stage
  logic        genClk;       // Generated clock

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        busReq   = wbReq.cyc & wbReq.stb & ~wbAck;
  wire        busWr    = busReq & wbReq.we;
  wire        busRd    = busReq & ~wbReq.we;
  wire [7:0]  wordAdr  = {wbReq.adr[7:2], 2'b00};
  wire        hitOut   = (wordAdr == OFS_OUT);
  wire        hitDir   = (wordAdr == OFS_DIR);
  wire        hitIn    = (wordAdr == OFS_IN);
  wire        hitIntEn = (wordAdr == OFS_INT_EN);
  wire        hitIntSt = (wordAdr == OFS_INT_ST);
  wire        hitClk   = (wordAdr == OFS_CLK_CFG);
  wire [31:0] byteMask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
                          {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};

  // Merge write data into a stored word under the byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Packed view of the clock setup for read and write
  wire [31:0] clkWord = {8'h00, clkCfg.high, clkCfg.div,
                         6'b000000, clkCfg.selB, clkCfg.selA};
  wire [31:0] clkNew  = merge(clkWord, wbReq.dat, byteMask);

  // Read multiplexer; unmapped words read as zero
  wire [31:0] rdMux =
    hitOut   ? {16'h0000, outData} :
    hitDir   ? {16'h0000, dir} :
    hitIn    ? {16'h0000, inSync} :
    hitIntEn ? {19'h00000, intEn} :
    hitIntSt ? {19'h00000, intStat} :
    hitClk   ? clkWord : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Wishbone answer: one wait state, ack for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wbAck    <= 1'b0;
      wbRdData <= 32'h0000_0000;
    end
    else
    begin
      wbAck    <= busReq;
      wbRdData <= busRd ? rdMux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Direction and output data
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      outData <= RST_OUT;
      dir     <= RST_DIR;
    end
    else
    begin
      if (busWr && hitOut)
        outData <= 16'(merge({16'h0000, outData}, wbReq.dat,
                             byteMask));
      if (busWr && hitDir)  // Per-pin direction
        dir <= 16'(merge({16'h0000, dir}, wbReq.dat, byteMask));
    end
  end

  // ----------------------------------------------------------------
  // Clock output setup and interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      clkCfg.selA <= RST_SEL_A;
      clkCfg.selB <= RST_SEL_B;
      clkCfg.div  <= RST_DIV;
      clkCfg.high <= RST_HIGH;
      intEn       <= RST_INT_EN;
    end
    else
    begin
      if (busWr && hitClk)  // Rate and duty
      begin
        clkCfg.selA <= clkNew[CLK_SEL_A_BIT];
        clkCfg.selB <= clkNew[CLK_SEL_B_BIT];
        clkCfg.div  <= clkNew[CLK_DIV_LSB +: 8];
        clkCfg.high <= clkNew[CLK_HIGH_LSB +: 8];
      end
      if (busWr && hitIntEn)
        intEn <= 13'(merge({19'h00000, intEn}, wbReq.dat,
                           byteMask));
    end
  end

  // ----------------------------------------------------------------
  // Reset release and lock tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      porMeta  <= 1'b0;
      porSync  <= 1'b0;
      lockMeta <= 1'b0;
      lockSync <= 1'b0;
    end
    else
    begin
      porMeta  <= power_up_reset_in_n;
      porSync  <= porMeta;
      lockMeta <= synthLockIn;
      lockSync <= lockMeta;
    end
  end

  // Pins leave high impedance only when all three conditions hold
  wire pinsLive = porSync & lockSync;

  // Report lock to the external reset logic
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      synthLocked <= 1'b0;
    else
      synthLocked <= lockSync;
  end

  // ----------------------------------------------------------------
  // Input synchronisers, one per pin
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_sync
      // Second stage alone reads the first one
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          inMeta[g] <= 1'b0;
          inSync[g] <= 1'b0;
          inLast[g] <= 1'b0;
        end
        else
        begin
          inMeta[g] <= pinIn[g];
          inSync[g] <= inMeta[g];
          inLast[g] <= inSync[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt events: rising edge on an input pin 0..12
  // ----------------------------------------------------------------
  wire [12:0] riseHit = inSync[12:0] & ~inLast[12:0] & ~dir[12:0];
  wire        stClr   = busRd & hitIntSt;   // Read clears status

  generate
    for (g = 0; g < IRQ_PINS; g++)
    begin : g_irq
      // Set wins over a clearing read in the same cycle
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          intStat[g] <= 1'b0;
        else if (riseHit[g])
          intStat[g] <= 1'b1;
        else if (stClr)
          intStat[g] <= 1'b0;
      end
    end
  endgenerate

  // Level interrupt while an enabled flag stands
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(intStat & intEn);
  end

  // ----------------------------------------------------------------
  // Clock generator shared by pins 14 and 15
  // ----------------------------------------------------------------
  wire clkRun = pinsLive & (clkCfg.selA | clkCfg.selB);

  gpio_clk_gen u_clk_gen
  (
    .clk    (clk),
    .rst_b  (rst_b),
    .run    (clkRun),
    .cfg    (clkCfg),
    .generated_clock_out (genClk)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  wire [15:0] clkSel  = {clkCfg.selB, clkCfg.selA, 14'h0000};
  wire [15:0] next_pinOut =
    (clkSel & {16{genClk}}) | (~clkSel & outData);
  // Clock selection forces the driver on
  wire [15:0] next_pinOe = {16{pinsLive}} & (dir | clkSel);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pinOut <= 16'h0000;
      pinOe  <= 16'h0000;   // Float during reset
    end
    else
    begin
      pinOut <= next_pinOut;
      pinOe  <= next_pinOe;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Lock held with reset released, so the chain has refilled
  sequence s_lockHeld;
    (rst_b && synthLockIn) [*3];
  endsequence

  sequence s_dirWrite;
    busWr && hitDir && (wbReq.sel == 4'hF);
  endsequence

  a_float_until_live:
    assert property (!pinsLive |=> (pinOe == 16'h0000))
    else $error("pin driven before resets released and lock");

  a_dir_after_reset:
    assert property ($past(!rst_b) |-> (dir == RST_DIR)
                     && (pinOe[13:0] == 14'h0000))
    else $error("pins 0-13 not inputs after reset");

  a_pin14_reset_in:
    assert property ($past(!rst_b) |-> !clkCfg.selA && !dir[14])
    else $error("pin 14 not input after reset");

  a_pin15_reset_clk:
    assert property ($past(!rst_b) |-> clkCfg.selB && dir[15])
    else $error("pin 15 not clock output after reset");

  a_clk_on_pin:
    assert property (pinsLive && clkCfg.selB
                     |=> pinOe[15] && (pinOut[15] == $past(genClk)))
    else $error("pin 15 does not carry the clock");

  a_dir_write:
    assert property (s_dirWrite |=> dir == $past(wbReq.dat[15:0]))
    else $error("direction write not taken");

  a_lock_report:
    assert property (s_lockHeld |=> synthLocked)
    else $error("lock not reported three cycles after input");

  a_sync_depth:
    assert property ($past(rst_b, 2) |-> inSync == $past(pinIn, 2))
    else $error("input not two stages behind pin");

  a_edge_sets:
    assert property ((riseHit != 13'h0000)
                     |=> (intStat & $past(riseHit)) == $past(riseHit))
    else $error("input edge did not set its flag");

  a_irq_level:
    assert property (|(intStat & intEn) |=> irq)
    else $error("interrupt low with enabled flag set");

  a_bus_ack:
    assert property (busReq |=> wbAck ##1 !wbAck)
    else $error("ack not a single cycle after request");

endmodule

// *** tb/board_pins.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Board side of the pins: pull-downs and external drivers
// ----------------------------------------------------------------
module board_pins
(
  input  wire logic [15:0] pinOut,
  input  wire logic [15:0] pinOe,
  input  wire logic [15:0] extVal,
  input  wire logic [15:0] extOe,
  output logic [15:0]      pinIn,
  output logic             expansion_bus_clock_in
);
  // Port driver first, then board driver, else the pull-down wins
  assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal);
  // Pin 15 is wired to the expansion bus clock input
  assign expansion_bus_clock_in = pinOe[15] & pinOut[15];
endmodule

// *** tb/general_purpose_pin_port_tb.sv ***
`timescale 1ns/10ps
module general_purpose_pin_port_tb;
  import gpio_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic we; logic [7:0] adr; logic [3:0] sel;
    logic [31:0] dat; logic [31:0] exp;
  } row_t;
  logic        clk;
  logic        rst_b;
  logic        pwrUpN;       // Power-up reset, active low
  logic        lockIn;       // Synthesizer lock from outside
  wb_req_t     wbReq;
  logic        wbAck;
  logic [31:0] wbRdData;
  logic [15:0] pinIn;
  logic [15:0] pinOut;
  logic [15:0] pinOe;
  logic [15:0] extVal;       // Board drive levels
  logic [15:0] extOe;        // Board drive enables
  logic        synthLocked;
  logic        irq;
  logic        expClk;       // Clock seen by the expansion bus
  wire  [16:0] tap = {expClk, pinOut};
  int          err_total;
  int          checks_done;
  int          cyc;
  logic [31:0] rd;
  logic [31:0] n;
  // Register accesses with the read data each should give
  row_t rows [8] = '{
    '{1'b1, OFS_DIR, 4'hF, 32'h0000_00FF, 32'h0},
    '{1'b0, OFS_DIR, 4'hF, 32'h0, 32'h0000_00FF},
    '{1'b1, OFS_OUT, 4'hF, 32'h0000_00A5, 32'h0},
    '{1'b1, OFS_OUT, 4'h2, 32'h0000_FFFF, 32'h0},
    '{1'b0, OFS_OUT, 4'hF, 32'h0, 32'h0000_FFA5},
    '{1'b0, 8'h20, 4'hF, 32'h0, 32'h0},
    '{1'b0, OFS_CLK_CFG, 4'hF, 32'h0, 32'h0001_0102},
    '{1'b0, OFS_INT_EN, 4'hF, 32'h0, 32'h0}};
  // ----------------------------------------------------------------
  // Design, board and clock
  // ----------------------------------------------------------------
  gpio_port uut (.clk(clk), .rst_b(rst_b), .power_up_reset_in_n(pwrUpN),
    .synthLockIn(lockIn), .wbReq(wbReq), .wbAck(wbAck),
    .wbRdData(wbRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .synthLocked(synthLocked), .irq(irq));
  board_pins board (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
    .extOe(extOe), .pinIn(pinIn), .expansion_bus_clock_in(expClk));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cuts a hang short
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge clk);
      cyc++;
      if (cyc == 6000)
      begin
        err_total++;
        tally_and_finish;
      end
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr,
    input logic [3:0] sel, input logic [31:0] dat, output logic [31:0] q);
    @(posedge clk);
    wbReq <= '{1'b1, 1'b1, we, adr, sel, dat};
    // Data is taken and the request dropped at the edge that sees ack
    do
      @(posedge clk);
    while (wbAck !== 1'b1);
    q = wbRdData;
    wbReq <= '0;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // High samples of one pin over 20 cycles
  task automatic cnt(input int idx, output logic [31:0] q);
    q = 32'h0;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      q = q + 32'(tap[idx]);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0; pwrUpN = 1'b0; lockIn = 1'b0; wbReq = '0;
    extVal = 16'h0000; extOe = 16'h7F00; err_total = 0; checks_done = 0;
    repeat (8) @(posedge clk);
    #1 cmp("pinOe in reset", 32'h0, 32'(pinOe));
    @(posedge clk);
    rst_b <= 1'b1;
    tick(10); cmp("pinOe power-up held", 32'h0, 32'(pinOe));
    @(posedge clk);
    pwrUpN <= 1'b1;
    tick(10); cmp("pinOe no lock", 32'h0, 32'(pinOe));
    cmp("locked early", 32'h0, 32'(synthLocked));
    @(posedge clk);
    lockIn <= 1'b1;
    tick(4); cmp("locked", 32'h1, 32'(synthLocked));
    tick(4); cmp("pinOe live", 32'h8000, 32'(pinOe));
    cnt(16, n); cmp("bus clock highs", 32'hA, n);
    $display("Test reset done");
    foreach (rows[i])
    begin
      wb(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat, rd);
      if (!rows[i].we) cmp("register read", rows[i].exp, rd);
    end
    tick(3); cmp("pinOe outputs", 32'h80FF, 32'(pinOe));
    cmp("pinOut low byte", 32'hA5, 32'(pinOut[7:0]));
    $display("Test registers done");
    @(posedge clk);
    extVal <= 16'h2A00;
    tick(4);
    wb(1'b1, OFS_IN, 4'hF, 32'hFFFF_FFFF, rd);
    wb(1'b0, OFS_IN, 4'hF, 32'h0, rd);
    cmp("IN levels", 32'h2AA5, rd & 32'h7FFF);
    wb(1'b0, OFS_INT_ST, 4'hF, 32'h0, rd);
    cmp("events", 32'h0A00, rd);
    wb(1'b0, OFS_INT_ST, 4'hF, 32'h0, rd);
    cmp("events cleared", 32'h0, rd);
    cmp("irq masked", 32'h0, 32'(irq));
    wb(1'b1, OFS_INT_EN, 4'hF, 32'h0200, rd);
    @(posedge clk);
    extVal <= 16'h2000;
    tick(5);
    @(posedge clk);
    extVal <= 16'h2600;
    tick(1); cmp("irq synchroniser", 32'h0, 32'(irq));
    tick(5); cmp("irq raised", 32'h1, 32'(irq));
    wb(1'b0, OFS_INT_ST, 4'hF, 32'h0, rd);
    cmp("events pending", 32'h0600, rd);
    tick(2); cmp("irq cleared", 32'h0, 32'(irq));
    @(posedge clk);
    extVal <= 16'h2200;
    tick(5);
    @(posedge clk);
    extVal <= 16'h2600;
    tick(6); cmp("irq unmasked only", 32'h0, 32'(irq));
    wb(1'b0, OFS_INT_ST, 4'hF, 32'h0, rd);
    cmp("masked event", 32'h0400, rd);
    $display("Test interrupts done");
    wb(1'b1, OFS_CLK_CFG, 4'hF, 32'h0001_0303, rd);
    tick(8); cmp("pinOe clocks", 32'hC0FF, 32'(pinOe));
    cnt(14, n); cmp("pin 14 highs", 32'h5, n);
    wb(1'b1, OFS_CLK_CFG, 4'hF, 32'h0003_0303, rd);
    tick(8);
    cnt(16, n); cmp("pin 15 duty", 32'hF, n);
    // Zero divider (one-cycle period) is clamped to the fastest legal rate
    wb(1'b1, OFS_CLK_CFG, 4'hF, 32'h0001_0003, rd);
    tick(8);
    cnt(14, n); cmp("pin 14 clamped", 32'hA, n);
    $display("Test clocks done");
    @(posedge clk);
    rst_b <= 1'b0;
    tick(2); cmp("pinOe second reset", 32'h0, 32'(pinOe));
    cmp("irq second reset", 32'h0, 32'(irq));
    @(posedge clk);
    rst_b <= 1'b1;
    tick(12); cmp("pinOe relive", 32'h8000, 32'(pinOe));
    wb(1'b0, OFS_DIR, 4'hF, 32'h0, rd);
    cmp("DIR reset", 32'h8000, rd);
    wb(1'b0, OFS_CLK_CFG, 4'hF, 32'h0, rd);
    cmp("CLK_CFG reset", 32'h0001_0102, rd);
    $display("Test mid-run reset done");
    tally_and_finish;
  end
endmodule
